// File: src/ufc_pkg.sv
package ufc_pkg;
	// Register locations on the internal register port
	localparam logic [3:0] FIFO_CTRL_ADDR = 4'h2;
	localparam logic [3:0] LINE_FMT_ADDR = 4'h3;
	localparam logic [7:0] FIFO_CTRL_RESET = 8'h00;
	localparam logic [7:0] LINE_FMT_RESET = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;
	// fifo_control fields
	localparam int FC_RX_TRIG_LO = 6;
	localparam int FC_TX_TRIG_LO = 4;
	localparam int FC_TX_FLUSH = 2;
	localparam int FC_RX_FLUSH = 1;
	localparam int FC_ENABLE = 0;
	// line_format_control fields
	localparam int LF_DIVISOR = 7;
	localparam int LF_BREAK = 6;
	localparam int LF_FORCE = 5;
	localparam int LF_TYPE = 4;
	localparam int LF_PAR_EN = 3;
	localparam int LF_STOP = 2;
	localparam int LF_LEN_LO = 0;
	// Trigger levels, characters held or spaces free
	localparam logic [6:0] RX_LVL_0 = 7'h08;
	localparam logic [6:0] RX_LVL_1 = 7'h10;
	localparam logic [6:0] RX_LVL_2 = 7'h38;
	localparam logic [6:0] RX_LVL_3 = 7'h3c;
	localparam logic [6:0] TX_LVL_0 = 7'h08;
	localparam logic [6:0] TX_LVL_1 = 7'h10;
	localparam logic [6:0] TX_LVL_2 = 7'h20;
	localparam logic [6:0] TX_LVL_3 = 7'h38;
	// Stop length in half bit times
	localparam logic [2:0] STOP_ONE = 3'h2;
	localparam logic [2:0] STOP_ONE_HALF = 3'h3;
	localparam logic [2:0] STOP_TWO = 3'h4;
	localparam logic [3:0] WORD_BITS_MIN = 4'h5;
	// Flush time in crystal clock periods
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int FLUSH_CLOCKS = 2;
	localparam int FLUSH_NS = FLUSH_CLOCKS * CLOCK_PERIOD_NS;
	localparam logic [1:0] FLUSH_CYCLES = 2'((FLUSH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} ufc_reg_req_t;

	typedef struct packed {
		logic divisor_access;
		logic break_on;
		logic parity_en;
		logic parity_forced;
		logic parity_even;
		logic [2:0] stop_half_bits;
		logic [3:0] word_bits;
	} ufc_line_fmt_t;

	// Parity bit for a character of the given length and mode
	function automatic logic ufc_parity(input logic [7:0] data, input logic [1:0] len,
		input logic forced, input logic type_sel);
		logic [7:0] mask;
		mask = 8'hff >> (2'h3 - len);
		if (forced) begin
			ufc_parity = ~type_sel;
		end else begin
			ufc_parity = (^(data & mask)) ^ ~type_sel;
		end
	endfunction : ufc_parity
endpackage : ufc_pkg

// File: src/ufc_ctrl.sv
`timescale 1ns/1ps

module ufc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4,
	parameter int CW = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	input wire logic flush,
	// Filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	// Level
	output logic [CW-1:0] count
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
		step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : step

	assign in_ready = !flush && (cnt_q != FULL);
	assign out_valid = !flush && (cnt_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_q];
	assign count = cnt_q;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= step(wr_q);
			end
			if (pop) begin
				rd_q <= step(rd_q);
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule : ufc_fifo

module ufc_ctrl import ufc_pkg::*; #(
	parameter int DEPTH = 64,
	parameter int CW = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Register port from the serial host interface
	input wire ufc_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic enhanced_function_enable,
	// Transmit holding location, host side
	input wire logic tx_hold_valid,
	input wire logic [7:0] tx_hold_data,
	output logic tx_hold_ready,
	// Towards the transmit shift register
	output logic tx_shift_valid,
	output logic [7:0] tx_shift_data,
	output logic tx_shift_parity,
	input wire logic tx_shift_ready,
	input wire logic tx_serial_in,
	output logic tx_line,
	// From the receive shift register
	input wire logic rx_shift_valid,
	input wire logic [7:0] rx_shift_data,
	input wire logic rx_shift_parity,
	output logic rx_shift_ready,
	// Receive holding location, host side
	output logic rx_hold_valid,
	output logic [7:0] rx_hold_data,
	output logic rx_hold_parity_err,
	input wire logic rx_hold_ready,
	// Format and status
	output ufc_line_fmt_t line_format,
	output logic fifo_enabled,
	output logic tx_flushing,
	output logic rx_flushing,
	output logic rx_threshold,
	output logic tx_threshold,
	output logic [CW-1:0] rx_level,
	output logic [CW-1:0] tx_free
);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [7:0] lcr_q;
	logic fifo_en_q;
	logic [1:0] rx_trig_q;
	logic [1:0] tx_trig_q;
	logic tx_trig_on_q;
	logic [1:0] tx_flush_q;
	logic [1:0] rx_flush_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic tx_line_q;
	logic fc_wr;
	logic lf_wr;
	logic [CW-1:0] tx_count;
	logic tx_gate;
	logic tx_fifo_ready;
	logic rx_gate;
	logic rx_fifo_ready;
	logic tx_par;
	logic rx_perr;
	logic [6:0] rx_lvl;
	logic [6:0] tx_lvl;

	assign fc_wr = reg_req.wr && (reg_req.addr == FIFO_CTRL_ADDR);
	assign lf_wr = reg_req.wr && (reg_req.addr == LINE_FMT_ADDR);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fifo_en_q <= FIFO_CTRL_RESET[FC_ENABLE];
			rx_trig_q <= FIFO_CTRL_RESET[FC_RX_TRIG_LO+:2];
		end else if (fc_wr) begin
			fifo_en_q <= reg_req.wdata[FC_ENABLE];
			rx_trig_q <= reg_req.wdata[FC_RX_TRIG_LO+:2];
		end
	end

	// Transmit trigger gated by enhanced enable
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_trig_q <= FIFO_CTRL_RESET[FC_TX_TRIG_LO+:2];
			tx_trig_on_q <= 1'b0;
		end else if (fc_wr && enhanced_function_enable) begin
			tx_trig_q <= reg_req.wdata[FC_TX_TRIG_LO+:2];
			tx_trig_on_q <= 1'b1;
		end
	end

	// Held for the full flush time
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_flush_q <= 2'h0;
		end else if (fc_wr && reg_req.wdata[FC_TX_FLUSH]) begin
			tx_flush_q <= FLUSH_CYCLES;
		end else if (tx_flush_q != 2'h0) begin
			tx_flush_q <= tx_flush_q - 2'h1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rx_flush_q <= 2'h0;
		end else if (fc_wr && reg_req.wdata[FC_RX_FLUSH]) begin
			rx_flush_q <= FLUSH_CYCLES;
		end else if (rx_flush_q != 2'h0) begin
			rx_flush_q <= rx_flush_q - 2'h1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lcr_q <= LINE_FMT_RESET;
		end else if (lf_wr) begin
			lcr_q <= reg_req.wdata;
		end
	end

	// Control location reads back as zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= READ_NONE;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_req.rd;
			if (reg_req.rd) begin
				rdata_q <= (reg_req.addr == LINE_FMT_ADDR) ? lcr_q : READ_NONE;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_line_q <= 1'b1;
		end else begin
			tx_line_q <= lcr_q[LF_BREAK] ? 1'b0 : tx_serial_in;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign tx_line = tx_line_q;
	assign fifo_enabled = fifo_en_q;
	assign tx_flushing = tx_flush_q != 2'h0;
	assign rx_flushing = rx_flush_q != 2'h0;

	always_comb begin
		line_format.divisor_access = lcr_q[LF_DIVISOR];
		line_format.break_on = lcr_q[LF_BREAK];
		line_format.parity_en = lcr_q[LF_PAR_EN];
		line_format.parity_forced = lcr_q[LF_FORCE];
		line_format.parity_even = lcr_q[LF_TYPE];
		line_format.word_bits = WORD_BITS_MIN + {2'h0, lcr_q[LF_LEN_LO+:2]};
		if (!lcr_q[LF_STOP]) begin
			line_format.stop_half_bits = STOP_ONE;
		end else if (lcr_q[LF_LEN_LO+:2] == 2'h0) begin
			line_format.stop_half_bits = STOP_ONE_HALF;
		end else begin
			line_format.stop_half_bits = STOP_TWO;
		end
	end

	assign tx_par = ufc_parity(tx_hold_data, lcr_q[LF_LEN_LO+:2], lcr_q[LF_FORCE], lcr_q[LF_TYPE]);
	assign rx_perr = lcr_q[LF_PAR_EN] &&
		(rx_shift_parity != ufc_parity(rx_shift_data, lcr_q[LF_LEN_LO+:2], lcr_q[LF_FORCE], lcr_q[LF_TYPE]));

	// With the FIFOs off only one entry is used, as a plain holding register
	assign tx_gate = fifo_en_q || (tx_count == '0);
	assign rx_gate = fifo_en_q || (rx_level == '0);
	assign tx_hold_ready = tx_fifo_ready && tx_gate;
	assign rx_shift_ready = rx_fifo_ready && rx_gate;

	ufc_fifo #(.WIDTH(9), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
		.clock(clock),
		.reset_n(reset_n),
		.flush(tx_flushing),
		.in_valid(tx_hold_valid && tx_gate),
		.in_data({tx_par, tx_hold_data}),
		.in_ready(tx_fifo_ready),
		.out_valid(tx_shift_valid),
		.out_data({tx_shift_parity, tx_shift_data}),
		.out_ready(tx_shift_ready),
		.count(tx_count)
	);

	ufc_fifo #(.WIDTH(9), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
		.clock(clock),
		.reset_n(reset_n),
		.flush(rx_flushing),
		.in_valid(rx_shift_valid && rx_gate),
		.in_data({rx_perr, rx_shift_data}),
		.in_ready(rx_fifo_ready),
		.out_valid(rx_hold_valid),
		.out_data({rx_hold_parity_err, rx_hold_data}),
		.out_ready(rx_hold_ready),
		.count(rx_level)
	);

	always_comb begin
		unique case (rx_trig_q)
			2'h0: rx_lvl = RX_LVL_0;
			2'h1: rx_lvl = RX_LVL_1;
			2'h2: rx_lvl = RX_LVL_2;
			2'h3: rx_lvl = RX_LVL_3;
		endcase
	end

	always_comb begin
		unique case (tx_trig_q)
			2'h0: tx_lvl = TX_LVL_0;
			2'h1: tx_lvl = TX_LVL_1;
			2'h2: tx_lvl = TX_LVL_2;
			2'h3: tx_lvl = TX_LVL_3;
		endcase
	end

	assign tx_free = FULL - tx_count;
	assign rx_threshold = CW'(rx_lvl) <= rx_level;
	assign tx_threshold = tx_trig_on_q && (CW'(tx_lvl) <= tx_free);

	sequence s_tx_flush_req;
		fc_wr && reg_req.wdata[FC_TX_FLUSH];
	endsequence
	sequence s_rx_flush_req;
		fc_wr && reg_req.wdata[FC_RX_FLUSH];
	endsequence
	sequence s_flush_tx_done;
		tx_flushing [*2] ##1 (!tx_flushing && tx_count == '0);
	endsequence
	sequence s_flush_rx_done;
		rx_flushing [*2] ##1 (!rx_flushing && rx_level == '0);
	endsequence

	chk_fc_read_zero: assert property (
		@(posedge clock) disable iff (!reset_n)
		(reg_req.rd && reg_req.addr == FIFO_CTRL_ADDR) |=> (reg_rvalid && reg_rdata == 8'h00))
		else $error("fifo control read returned data");
	chk_rx_trig_level: assert property (
		@(posedge clock) disable iff (!reset_n)
		(rx_trig_q == 2'h2) |-> (rx_threshold == (rx_level >= CW'(56))))
		else $error("receive threshold wrong at level 56");
	chk_tx_trig_level: assert property (
		@(posedge clock) disable iff (!reset_n)
		(tx_trig_on_q && tx_trig_q == 2'h2) |-> (tx_threshold == (tx_free >= CW'(32))))
		else $error("transmit threshold wrong at 32 spaces");
	chk_tx_trig_locked: assert property (
		@(posedge clock) disable iff (!reset_n)
		(fc_wr && !enhanced_function_enable) |=> ($stable(tx_trig_q) && $stable(tx_trig_on_q)))
		else $error("transmit trigger changed without enhanced enable");
	chk_tx_flush_seq: assert property (
		@(posedge clock) disable iff (!reset_n)
		s_tx_flush_req |=> s_flush_tx_done)
		else $error("transmit flush did not complete in two cycles");
	chk_rx_flush_seq: assert property (
		@(posedge clock) disable iff (!reset_n)
		s_rx_flush_req |=> s_flush_rx_done)
		else $error("receive flush did not complete in two cycles");
	chk_flush_blocks_host: assert property (
		@(posedge clock) disable iff (!reset_n)
		(tx_flushing || rx_flushing) |-> (!(tx_flushing && tx_hold_ready) && !(rx_flushing && rx_hold_valid)))
		else $error("holding location usable during flush");
	chk_fifo_enable: assert property (
		@(posedge clock) disable iff (!reset_n)
		fc_wr |=> (fifo_enabled == $past(reg_req.wdata[FC_ENABLE])))
		else $error("fifo enable did not follow write");
	chk_divisor_flag: assert property (
		@(posedge clock) disable iff (!reset_n)
		lf_wr |=> (line_format.divisor_access == $past(reg_req.wdata[LF_DIVISOR])))
		else $error("divisor access flag wrong");
	chk_break_low: assert property (
		@(posedge clock) disable iff (!reset_n)
		line_format.break_on |=> !tx_line)
		else $error("line not low during break");
	chk_forced_parity: assert property (
		@(posedge clock) disable iff (!reset_n)
		lcr_q[LF_FORCE] |-> (tx_par == !lcr_q[LF_TYPE]))
		else $error("forced parity bit wrong");
	chk_stop_length: assert property (
		@(posedge clock) disable iff (!reset_n)
		(lcr_q[LF_STOP] && lcr_q[LF_LEN_LO+:2] != 2'h0) |-> (line_format.stop_half_bits == 3'h4))
		else $error("two stop bits expected");
endmodule : ufc_ctrl

// File: sim/ufc_host_model.sv
`timescale 1ns/1ps

module ufc_host_model import ufc_pkg::*; (
	// Clock
	input wire logic clock,
	// Register port
	output ufc_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// Transmit holding location
	output logic tx_hold_valid,
	output logic [7:0] tx_hold_data,
	input wire logic tx_hold_ready
);
	initial begin
		reg_req = '0;
		tx_hold_valid = 1'b0;
		tx_hold_data = 8'h00;
	end

	task automatic reg_wr(input logic [3:0] addr, input logic [7:0] data);
		@(negedge clock);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(negedge clock);
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] addr, output logic [7:0] data, output logic ok);
		@(negedge clock);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(negedge clock);
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
		ok = reg_rvalid;
		data = reg_rdata;
	endtask : reg_rd

	task automatic flush_wait;
		repeat (FLUSH_CLOCKS + 1) @(negedge clock);
	endtask : flush_wait

	// Ready is looked at on the falling edge, well away from the flop updates
	task automatic tx_push(input logic [7:0] data, output logic ok);
		int n;
		n = 0;
		@(negedge clock);
		while (!tx_hold_ready && n < 8) begin
			n++;
			@(negedge clock);
		end
		tx_hold_valid = 1'b1;
		tx_hold_data = data;
		@(negedge clock);
		tx_hold_valid = 1'b0;
		tx_hold_data = ~data;
		ok = (n < 8);
	endtask : tx_push
endmodule : ufc_host_model

// File: sim/ufc_ctrl_tb_top.sv
`timescale 1ns/1ps

module ufc_ctrl_tb_top import ufc_pkg::*; ;
	logic clock, reset_n, enh, tx_serial_in, tx_shift_ready, rx_shift_valid, rx_shift_parity, rx_hold_ready;
	logic [7:0] rx_shift_data, reg_rdata, tx_hold_data, tx_shift_data, rx_hold_data, rd;
	logic reg_rvalid, tx_hold_valid, tx_hold_ready, tx_shift_valid, tx_shift_parity, tx_line, ok;
	logic rx_shift_ready, rx_hold_valid, rx_hold_parity_err, fifo_enabled, tx_flushing, rx_flushing;
	logic rx_threshold, tx_threshold;
	logic [6:0] rx_level, tx_free;
	ufc_reg_req_t reg_req;
	ufc_line_fmt_t line_format;
	logic [6:0] rx_lvl [4] = '{RX_LVL_0, RX_LVL_1, RX_LVL_2, RX_LVL_3};
	logic [6:0] tx_lvl [4] = '{TX_LVL_0, TX_LVL_1, TX_LVL_2, TX_LVL_3};
	int n_fail = 0;
	int tests_run = 0;

	initial clock = 1'b0;
	always #5 clock = ~clock;

	ufc_host_model host_u (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.tx_hold_valid(tx_hold_valid), .tx_hold_data(tx_hold_data), .tx_hold_ready(tx_hold_ready));

	ufc_ctrl dut_u (.clock(clock), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .enhanced_function_enable(enh), .tx_hold_valid(tx_hold_valid),
		.tx_hold_data(tx_hold_data), .tx_hold_ready(tx_hold_ready), .tx_shift_valid(tx_shift_valid),
		.tx_shift_data(tx_shift_data), .tx_shift_parity(tx_shift_parity), .tx_shift_ready(tx_shift_ready),
		.tx_serial_in(tx_serial_in), .tx_line(tx_line), .rx_shift_valid(rx_shift_valid),
		.rx_shift_data(rx_shift_data), .rx_shift_parity(rx_shift_parity), .rx_shift_ready(rx_shift_ready),
		.rx_hold_valid(rx_hold_valid), .rx_hold_data(rx_hold_data), .rx_hold_parity_err(rx_hold_parity_err),
		.rx_hold_ready(rx_hold_ready), .line_format(line_format), .fifo_enabled(fifo_enabled),
		.tx_flushing(tx_flushing), .rx_flushing(rx_flushing), .rx_threshold(rx_threshold),
		.tx_threshold(tx_threshold), .rx_level(rx_level), .tx_free(tx_free));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	// Character zero goes in with a wrong even parity bit on purpose
	task automatic rx_push(input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clock);
		while (!rx_shift_ready && n < 8) begin
			n++;
			@(negedge clock);
		end
		rx_shift_valid = 1'b1;
		rx_shift_data = d;
		rx_shift_parity = (d == 8'h00) ? 1'b1 : ^d;
		@(negedge clock);
		rx_shift_valid = 1'b0;
		rx_shift_data = ~d;
		check(8'(n < 8), 8'h01, "rx ready");
	endtask : rx_push

	initial begin
		#(20000 * 10);
		n_fail++;
		end_of_test();
	end

	initial begin
		reset_n = 1'b0;
		enh = 1'b0;
		tx_serial_in = 1'b1;
		tx_shift_ready = 1'b0;
		rx_shift_valid = 1'b0;
		rx_shift_data = 8'h00;
		rx_shift_parity = 1'b0;
		rx_hold_ready = 1'b0;
		repeat (3) @(negedge clock);
		reset_n = 1'b1;
		check(8'(line_format.word_bits), 8'h05, "reset length");
		check(8'(fifo_enabled), 8'h00, "reset enable");
		check(8'(tx_line), 8'h01, "reset line");
		check(8'(tx_free), 8'h40, "reset free");
		check(8'(tx_threshold), 8'h00, "reset tx trig");
		$display("test reset done");
		for (int l = 0; l < 4; l++) begin
			host_u.reg_wr(LINE_FMT_ADDR, 8'h04 | 8'(l));
			check(8'(line_format.word_bits), 8'(5 + l), "length");
			check(8'(line_format.stop_half_bits), (l == 0) ? 8'h03 : 8'h04, "stop");
			host_u.reg_rd(LINE_FMT_ADDR, rd, ok);
			check(rd, 8'h04 | 8'(l), "format readback");
		end
		host_u.reg_wr(LINE_FMT_ADDR, 8'h03);
		check(8'(line_format.stop_half_bits), 8'h02, "one stop");
		for (int p = 0; p < 4; p++) begin
			host_u.reg_wr(LINE_FMT_ADDR, {2'b00, 2'(p), 4'hb});
			check(8'({line_format.parity_en, line_format.parity_forced, line_format.parity_even}), 8'h04 | 8'(p),
				"parity mode");
			host_u.tx_push(8'h07, ok);
			check(8'(tx_shift_valid), 8'h01, "tx head");
			check(8'(tx_hold_ready), 8'h00, "single entry");
			check(tx_shift_data, 8'h07, "tx data");
			check(8'(tx_shift_parity), (p >= 2) ? 8'(p == 2) : 8'(p == 1), "tx parity");
			tx_shift_ready = 1'b1;
			@(negedge clock);
			tx_shift_ready = 1'b0;
		end
		host_u.reg_wr(LINE_FMT_ADDR, 8'hc3);
		check(8'(line_format.divisor_access), 8'h01, "divisor");
		@(negedge clock);
		check(8'(tx_line), 8'h00, "break low");
		host_u.reg_wr(LINE_FMT_ADDR, 8'h1b);
		@(negedge clock);
		check(8'(tx_line), 8'h01, "break over");
		$display("test line format done");
		host_u.reg_wr(FIFO_CTRL_ADDR, 8'h31);
		check(8'(fifo_enabled), 8'h01, "enable");
		check(8'(tx_threshold), 8'h00, "tx trig locked");
		host_u.reg_rd(FIFO_CTRL_ADDR, rd, ok);
		check({ok, rd[6:0]}, {1'b1, READ_NONE[6:0]}, "fifo ctrl read");
		check(rd, READ_NONE, "fifo ctrl data");
		host_u.reg_rd(4'hf, rd, ok);
		check(rd, READ_NONE, "unmapped read");
		host_u.reg_wr(FIFO_CTRL_ADDR, 8'h08);
		check(8'(fifo_enabled), 8'h00, "reserved bit");
		$display("test fifo control done");
		for (int c = 0; c < 4; c++) begin
			host_u.reg_wr(FIFO_CTRL_ADDR, {2'(c), 6'h03});
			check(8'(rx_flushing), 8'h01, "rx flush 1");
			@(negedge clock);
			check(8'(rx_flushing), 8'h01, "rx flush 2");
			@(negedge clock);
			check(8'({rx_flushing, rx_hold_valid}), 8'h00, "rx flushed");
			check(8'(rx_level), 8'h00, "rx level cleared");
			for (int i = 0; i < rx_lvl[c] - 1; i++) rx_push(8'(i));
			check(8'(rx_threshold), 8'h00, "rx below");
			rx_push(8'hff);
			check(8'(rx_threshold), 8'h01, "rx at level");
		end
		check({rx_hold_data[6:0], rx_hold_parity_err}, 8'h01, "rx bad parity");
		rx_hold_ready = 1'b1;
		@(negedge clock);
		rx_hold_ready = 1'b0;
		check({rx_hold_data[6:0], rx_hold_parity_err}, 8'h02, "rx good parity");
		$display("test receive done");
		enh = 1'b1;
		for (int c = 0; c < 4; c++) begin
			host_u.reg_wr(FIFO_CTRL_ADDR, {2'b00, 2'(c), 4'h5});
			check(8'(tx_flushing), 8'h01, "tx flush");
			host_u.flush_wait();
			check(8'({tx_flushing, tx_shift_valid}), 8'h00, "tx flushed");
			check(8'(tx_free), 8'h40, "tx free restored");
			for (int i = 0; i < 64 - tx_lvl[c]; i++) host_u.tx_push(8'(i), ok);
			check(8'(tx_threshold), 8'h01, "tx at level");
			host_u.tx_push(8'haa, ok);
			check(8'(tx_threshold), 8'h00, "tx below");
		end
		enh = 1'b0;
		host_u.reg_wr(FIFO_CTRL_ADDR, 8'h01);
		check(8'(tx_threshold), 8'h00, "tx trig kept");
		$display("test transmit done");
		end_of_test();
	end
endmodule : ufc_ctrl_tb_top
